// >>> logic/jcc_jump_control.sv
// Program flow control for numbered jumps and the multiple skip pair of a ladder execution engine.
// Assumes the engine issues one instruction, then waits for the answer before issuing the next.
// Behaviour
// - Function code 004 is the jump that fires when its condition is off and 005 is the jump end marker.
// - Outside block program areas a jump_when_off whose condition is on does not jump and execution goes on in sequence.
// - A jump_when_off whose condition is off sends execution to the first marker with its number.
// - Jump numbers 0000 to 03FF are accepted for the plain and the conditional jumps.
// - On the reduced model only jump numbers 0000 to 00FF are valid.
// - The error flag is set for a number out of range or with no marker in the task, and cleared otherwise.
// - Skipped instructions are not executed and their bit and word outputs hold.
// - Running timers in a skipped section keep updating their present values.
// - Among markers sharing a number only the one at the lowest address is the target.
// - A marker before its jump makes the section between them repeat while the jump keeps firing.
// - A backward loop still running at the maximum cycle time raises the cycle time too long error.
// - Inside block program areas the jump_when_off always skips to its marker.
// - An edge detector in a skipped section compares against the value held before the jump.
// - Numbered jumps cost no time for skipped instructions, while the multiple skip runs them as no-ops.
// - The conditional_jump_off jumps when its condition is off and runs on in sequence when it is on.
`timescale 1ns/1ps
module jcc_jump_control #(
	parameter int MAX_CYCLE_TIME_MS = jcc_pkg::MAX_CYCLE_TIME_MS_DEFAULT
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Model selection
	input wire logic i_reduced_model,
	// Target table loading
	input wire logic i_tbl_clear,
	input wire logic i_tbl_load,
	input wire logic [jcc_pkg::TBL_IDX_W-1:0] i_tbl_num,
	input wire logic [jcc_pkg::ADDR_W-1:0] i_tbl_addr,
	input wire logic [jcc_pkg::OWNER_W-1:0] i_tbl_owner,
	// Scan framing
	input wire logic i_scan_start,
	input wire logic i_scan_end,
	// Instruction issue
	input wire logic i_instr_valid,
	input wire logic [jcc_pkg::OPC_W-1:0] i_opcode,
	input wire logic [jcc_pkg::NUM_W-1:0] i_operand,
	input wire logic [jcc_pkg::ADDR_W-1:0] i_addr,
	input wire logic [jcc_pkg::OWNER_W-1:0] i_owner,
	input wire logic i_exec_cond,
	input wire logic i_block_area,
	// Timer service
	input wire logic i_timer_tick,
	// Answer
	output logic o_resp_valid,
	output logic o_exec_enable,
	output logic o_jump,
	output logic [jcc_pkg::ADDR_W-1:0] o_jump_addr,
	output logic o_multi_skip,
	// Status
	output logic o_error_flag,
	output logic o_cycle_too_long,
	output logic o_timer_service
);
	import jcc_pkg::*;

	localparam logic [31:0] WDOG_CYCLES = 32'(MAX_CYCLE_TIME_MS * CLK_KHZ);

	typedef struct packed {
		logic resp_valid;
		logic exec_en;
		logic jump;
		logic [ADDR_W-1:0] jump_addr;
		logic multi_skip;
		logic error_flag;
		logic too_long;
		logic timer_service;
		logic loop_active;
		logic [31:0] wdog_cnt;
	} jcc_state_s;

	jcc_state_s st_r;
	jcc_state_s st_nxt;

	jcc_class_e cls;
	logic look_hit;
	logic [ADDR_W-1:0] look_addr;
	logic [OWNER_W-1:0] look_owner;
	logic [NUM_W-1:0] num_limit;
	logic range_ok;
	logic target_ok;
	logic want_jump;

	jcc_target_table u_table (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_clear(i_tbl_clear),
		.i_load_valid(i_tbl_load),
		.i_load_num(i_tbl_num),
		.i_load_addr(i_tbl_addr),
		.i_load_owner(i_tbl_owner),
		.i_look_num(i_operand[TBL_IDX_W-1:0]),
		.o_look_hit(look_hit),
		.o_look_addr(look_addr),
		.o_look_owner(look_owner)
	);

	always_comb begin
		cls = jcc_decode(i_opcode);
		num_limit = JNUM_MAX_FULL;
		if (i_reduced_model) begin
			num_limit = JNUM_MAX_REDUCED;
		end
		range_ok = (i_operand <= num_limit);
		target_ok = range_ok && look_hit && (look_owner == i_owner);
		case (cls)
			CL_JUMP_WHEN_OFF: want_jump = i_block_area || !i_exec_cond;
			CL_COND_ON: want_jump = i_exec_cond;
			CL_COND_OFF: want_jump = !i_exec_cond;
			default: want_jump = 1'b0;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.resp_valid = 1'b0;
		st_nxt.jump = 1'b0;
		st_nxt.exec_en = 1'b0;
		st_nxt.timer_service = i_timer_tick;

		// Counting saturates so a stuck loop cannot wrap back below the limit.
		if (i_scan_start || i_scan_end) begin
			st_nxt.wdog_cnt = WDOG_CNT_RESET;
			st_nxt.loop_active = 1'b0;
		end else if (st_r.wdog_cnt != WDOG_CYCLES) begin
			st_nxt.wdog_cnt = st_r.wdog_cnt + 32'h0000_0001;
		end
		if (st_r.loop_active && (st_r.wdog_cnt == WDOG_CYCLES) && !i_scan_start && !i_scan_end) begin
			st_nxt.too_long = 1'b1;
		end

		if (i_instr_valid) begin
			st_nxt.resp_valid = 1'b1;
			if (st_r.multi_skip) begin
				if (cls == CL_MSKIP_END) begin
					st_nxt.multi_skip = 1'b0;
				end
			end else begin
				case (cls)
					CL_JUMP_WHEN_OFF, CL_COND_ON, CL_COND_OFF: begin
						st_nxt.error_flag = !target_ok;
						if (target_ok && want_jump) begin
							st_nxt.jump = 1'b1;
							st_nxt.jump_addr = look_addr;
							if (look_addr <= i_addr) begin
								st_nxt.loop_active = 1'b1;
							end
						end
					end
					CL_MSKIP_START: begin
						st_nxt.multi_skip = !i_exec_cond;
					end
					CL_JUMP_END, CL_MSKIP_END: begin
						st_nxt.exec_en = 1'b0;
					end
					default: begin
						// edge memory only written when run
						st_nxt.exec_en = 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st_r.resp_valid <= 1'b0;
			st_r.exec_en <= 1'b0;
			st_r.jump <= 1'b0;
			st_r.jump_addr <= JUMP_ADDR_RESET;
			st_r.multi_skip <= 1'b0;
			st_r.error_flag <= 1'b0;
			st_r.too_long <= 1'b0;
			st_r.timer_service <= 1'b0;
			st_r.loop_active <= 1'b0;
			st_r.wdog_cnt <= WDOG_CNT_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_resp_valid = st_r.resp_valid;
	assign o_exec_enable = st_r.exec_en;
	assign o_jump = st_r.jump;
	assign o_jump_addr = st_r.jump_addr;
	assign o_multi_skip = st_r.multi_skip;
	assign o_error_flag = st_r.error_flag;
	assign o_cycle_too_long = st_r.too_long;
	assign o_timer_service = st_r.timer_service;

endmodule

// >>> include/jcc_pkg.sv
// Constants, types and decoding shared by the jump control block and its target table.
// Assumes a single 40 MHz clock and an execution engine that issues one instruction at a time.
package jcc_pkg;

	localparam int OPC_W = 10;
	localparam int ADDR_W = 16;
	localparam int NUM_W = 16;
	localparam int OWNER_W = 8;
	localparam int TBL_IDX_W = 10;
	localparam int TBL_DEPTH = 1024;

	// Function codes of the flow instructions.
	localparam logic [OPC_W-1:0] FC_JUMP_WHEN_OFF = 10'h004;
	localparam logic [OPC_W-1:0] FC_JUMP_END_MARKER = 10'h005;
	localparam logic [OPC_W-1:0] FC_CONDITIONAL_JUMP_ON = 10'h1FE;
	localparam logic [OPC_W-1:0] FC_CONDITIONAL_JUMP_OFF = 10'h1FF;
	localparam logic [OPC_W-1:0] FC_MULTIPLE_SKIP_START = 10'h203;
	localparam logic [OPC_W-1:0] FC_MULTIPLE_SKIP_END = 10'h204;

	// Highest legal jump numbers.
	localparam logic [NUM_W-1:0] JNUM_MAX_FULL = 16'h03FF;
	localparam logic [NUM_W-1:0] JNUM_MAX_REDUCED = 16'h00FF;

	// Timing.
	localparam int CLK_KHZ = 40000;
	localparam int MAX_CYCLE_TIME_MS_DEFAULT = 1000;

	// Reset values.
	localparam logic [31:0] WDOG_CNT_RESET = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] JUMP_ADDR_RESET = 16'h0000;

	typedef enum logic [2:0] {
		CL_OTHER = 3'b000,
		CL_JUMP_WHEN_OFF = 3'b001,
		CL_JUMP_END = 3'b010,
		CL_COND_ON = 3'b011,
		CL_COND_OFF = 3'b100,
		CL_MSKIP_START = 3'b101,
		CL_MSKIP_END = 3'b110
	} jcc_class_e;

	function automatic jcc_class_e jcc_decode(input logic [OPC_W-1:0] opc);
		jcc_class_e c;
		case (opc)
			FC_JUMP_WHEN_OFF: c = CL_JUMP_WHEN_OFF;
			FC_JUMP_END_MARKER: c = CL_JUMP_END;
			FC_CONDITIONAL_JUMP_ON: c = CL_COND_ON;
			FC_CONDITIONAL_JUMP_OFF: c = CL_COND_OFF;
			FC_MULTIPLE_SKIP_START: c = CL_MSKIP_START;
			FC_MULTIPLE_SKIP_END: c = CL_MSKIP_END;
			default: c = CL_OTHER;
		endcase
		return c;
	endfunction

endpackage

// >>> logic/jcc_target_table.sv
// Table of jump end marker positions, one entry per jump number.
// Assumes the loader presents every marker of the program once after a clear, in any order.
`timescale 1ns/1ps
module jcc_target_table (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Loading
	input wire logic i_clear,
	input wire logic i_load_valid,
	input wire logic [jcc_pkg::TBL_IDX_W-1:0] i_load_num,
	input wire logic [jcc_pkg::ADDR_W-1:0] i_load_addr,
	input wire logic [jcc_pkg::OWNER_W-1:0] i_load_owner,
	// Lookup
	input wire logic [jcc_pkg::TBL_IDX_W-1:0] i_look_num,
	output logic o_look_hit,
	output logic [jcc_pkg::ADDR_W-1:0] o_look_addr,
	output logic [jcc_pkg::OWNER_W-1:0] o_look_owner
);
	import jcc_pkg::*;

	typedef struct packed {
		logic [TBL_DEPTH-1:0] valid;
		logic [TBL_DEPTH-1:0][ADDR_W-1:0] addr;
		logic [TBL_DEPTH-1:0][OWNER_W-1:0] owner;
	} jcc_tbl_s;

	jcc_tbl_s tbl_r;
	jcc_tbl_s tbl_nxt;

	always_comb begin
		tbl_nxt = tbl_r;
		if (i_clear) begin
			tbl_nxt.valid = '0;
		end else if (i_load_valid) begin
			if (!tbl_r.valid[i_load_num] || (i_load_addr < tbl_r.addr[i_load_num])) begin
				tbl_nxt.valid[i_load_num] = 1'b1;
				tbl_nxt.addr[i_load_num] = i_load_addr;
				tbl_nxt.owner[i_load_num] = i_load_owner;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			tbl_r <= '0;
		end else begin
			tbl_r <= tbl_nxt;
		end
	end

	assign o_look_hit = tbl_r.valid[i_look_num];
	assign o_look_addr = tbl_r.addr[i_look_num];
	assign o_look_owner = tbl_r.owner[i_look_num];

endmodule

// >>> testbench/jcc_monitor.sv
// Checker for the answers of the jump control block.
// Assumes one instruction is issued at a time, as the block expects.
`timescale 1ns/1ps
module jcc_monitor (
	// Inputs
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_reduced_model,
	input wire logic i_instr_valid,
	input wire logic [jcc_pkg::OPC_W-1:0] i_opcode,
	input wire logic [jcc_pkg::NUM_W-1:0] i_operand,
	input wire logic i_exec_cond,
	input wire logic i_block_area,
	input wire logic i_timer_tick,
	// Outputs
	input wire logic o_resp_valid,
	input wire logic o_exec_enable,
	input wire logic o_jump,
	input wire logic o_multi_skip,
	input wire logic o_error_flag,
	input wire logic o_cycle_too_long,
	input wire logic o_timer_service
);
	import jcc_pkg::*;
	logic live;
	logic jw;
	logic co;
	logic cf;
	logic nj;
	assign live = i_instr_valid && !o_multi_skip;
	assign jw = live && i_opcode == FC_JUMP_WHEN_OFF;
	assign co = live && i_opcode == FC_CONDITIONAL_JUMP_ON;
	assign cf = live && i_opcode == FC_CONDITIONAL_JUMP_OFF;
	assign nj = jw || co || cf;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	AST_ANSWER: assert property (i_instr_valid |=> o_resp_valid ##1 !o_resp_valid) else $error("no answer");
	AST_JUMP_HOLDS: assert property (o_jump |-> o_resp_valid && !o_exec_enable) else $error("jump executed");
	AST_ON_STAYS: assert property (jw && i_exec_cond && !i_block_area |=> !o_jump) else $error("jumped on");
	AST_RANGE: assert property (nj && i_operand > JNUM_MAX_FULL |=> o_error_flag && !o_jump) else $error("range");
	AST_REDUCED: assert property (nj && i_reduced_model && i_operand > JNUM_MAX_REDUCED |=> o_error_flag)
		else $error("reduced range");
	AST_CJ_ON: assert property (co && !i_exec_cond |=> !o_jump) else $error("on jump fired");
	AST_CJ_OFF: assert property (cf && i_exec_cond |=> !o_jump) else $error("off jump fired");
	AST_SKIP_NOP: assert property (o_multi_skip && i_instr_valid |=> !o_exec_enable && !o_jump)
		else $error("skip executed");
	AST_TIMER: assert property (i_timer_tick |=> o_timer_service) else $error("timer lost");
	AST_STICKY: assert property (o_cycle_too_long |=> o_cycle_too_long) else $error("cycle flag dropped");
	AST_FLAG_HOLD: assert property (!o_resp_valid |-> $stable(o_error_flag)) else $error("flag moved");
endmodule
bind jcc_jump_control jcc_monitor u_mon (.i_clk, .i_reset, .i_reduced_model, .i_instr_valid, .i_opcode,
	.i_operand, .i_exec_cond, .i_block_area, .i_timer_tick, .o_resp_valid, .o_exec_enable, .o_jump,
	.o_multi_skip, .o_error_flag, .o_cycle_too_long, .o_timer_service);

// >>> testbench/jcc_tb.sv
// Self-checking bench for the jump control block.
// Assumes a cycle limit of zero, so any backward jump flags at once.
`timescale 1ns/1ps
module testbench;
	import jcc_pkg::*;
	logic i_clk = 0, i_reset = 1, i_reduced_model = 0, i_tbl_clear = 0, i_tbl_load = 0;
	logic i_scan_start = 0, i_scan_end = 0, i_instr_valid = 0, i_exec_cond = 0, i_block_area = 0, i_timer_tick = 0;
	logic [9:0] i_tbl_num = 0, i_opcode = 0;
	logic [15:0] i_tbl_addr = 0, i_operand = 0, i_addr = 0, o_jump_addr;
	logic [7:0] i_tbl_owner = 0, i_owner = 8'h01;
	logic o_resp_valid, o_exec_enable, o_jump, o_multi_skip, o_error_flag, o_cycle_too_long, o_timer_service;
	int err_total = 0, samples_checked = 0;
	jcc_jump_control #(.MAX_CYCLE_TIME_MS(0)) uut (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_reduced_model(i_reduced_model),
		.i_tbl_clear(i_tbl_clear),
		.i_tbl_load(i_tbl_load),
		.i_tbl_num(i_tbl_num),
		.i_tbl_addr(i_tbl_addr),
		.i_tbl_owner(i_tbl_owner),
		.i_scan_start(i_scan_start),
		.i_scan_end(i_scan_end),
		.i_instr_valid(i_instr_valid),
		.i_opcode(i_opcode),
		.i_operand(i_operand),
		.i_addr(i_addr),
		.i_owner(i_owner),
		.i_exec_cond(i_exec_cond),
		.i_block_area(i_block_area),
		.i_timer_tick(i_timer_tick),
		.o_resp_valid(o_resp_valid),
		.o_exec_enable(o_exec_enable),
		.o_jump(o_jump),
		.o_jump_addr(o_jump_addr),
		.o_multi_skip(o_multi_skip),
		.o_error_flag(o_error_flag),
		.o_cycle_too_long(o_cycle_too_long),
		.o_timer_service(o_timer_service)
	);
	initial forever #12.5 i_clk = ~i_clk;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic load(input logic [9:0] n, input logic [15:0] a);
		@(posedge i_clk);
		i_tbl_load <= 1'b1;
		i_tbl_num <= n;
		i_tbl_addr <= a;
		i_tbl_owner <= 8'h01;
		@(posedge i_clk);
		i_tbl_load <= 1'b0;
	endtask
	task automatic iss(input logic [9:0] op, input logic [15:0] n, a, input logic c, b);
		@(posedge i_clk);
		i_instr_valid <= 1'b1;
		i_opcode <= op;
		i_operand <= n;
		i_addr <= a;
		i_exec_cond <= c;
		i_block_area <= b;
		@(posedge i_clk);
		i_instr_valid <= 1'b0;
		#1;
	endtask
	// A taken jump is followed by its marker, since the engine must go to the target next.
	task automatic run(input logic [9:0] op, input logic [15:0] n, a, input logic c, b, input logic [15:0] t, input logic e);
		iss(op, n, a, c, b);
		chk(16'({o_resp_valid, o_jump, o_error_flag}), 16'({1'b1, t != 16'h0000, e}));
		if (t != 16'h0000) begin
			chk(o_jump_addr, t);
			chk(16'(o_exec_enable), 16'h0000);
			iss(FC_JUMP_END_MARKER, n, t, 1'b1, 1'b0);
		end
	endtask
	task automatic t_range();
		@(posedge i_clk) i_tbl_clear <= 1'b1;
		@(posedge i_clk) i_tbl_clear <= 1'b0;
		run(10'h004, 16'h03FF, 16'h0100, 0, 0, 16'h0000, 1);
		load(10'h3FF, 16'h0200);
		run(10'h004, 16'h03FF, 16'h0100, 0, 0, 16'h0200, 0);
		// The low ten bits select the loaded entry, so only the range check can raise the flag here.
		run(10'h1FF, 16'h07FF, 16'h0100, 0, 0, 16'h0000, 1);
		load(10'h100, 16'h0210);
		@(posedge i_clk) i_reduced_model <= 1'b1;
		run(10'h004, 16'h0100, 16'h0100, 0, 0, 16'h0000, 1);
		@(posedge i_clk) i_reduced_model <= 1'b0;
		run(10'h004, 16'h0100, 16'h0100, 0, 0, 16'h0210, 0);
		@(posedge i_clk) i_owner <= 8'h02;
		run(10'h004, 16'h0100, 16'h0100, 0, 0, 16'h0000, 1);
		@(posedge i_clk) i_owner <= 8'h01;
		$display("t_range done");
	endtask
	task automatic t_basic();
		load(10'h005, 16'h0040);
		load(10'h005, 16'h0030);
		load(10'h005, 16'h0050);
		run(10'h004, 16'h0005, 16'h0010, 1, 0, 16'h0000, 0);
		run(10'h004, 16'h0005, 16'h0010, 0, 0, 16'h0030, 0);
		run(10'h100, 16'h0000, 16'h0031, 1, 0, 16'h0000, 0);
		chk(16'(o_exec_enable), 16'h0001);
		$display("t_basic done");
	endtask
	task automatic t_cond();
		logic [9:0] ops [5] = '{10'h004, 10'h1FE, 10'h1FE, 10'h1FF, 10'h1FF};
		logic cs [5] = '{1, 1, 0, 0, 1};
		logic js [5] = '{1, 1, 0, 1, 0};
		for (int k = 0; k < 5; k++) begin
			run(ops[k], 16'h0005, 16'h0010, cs[k], k == 0, js[k] ? 16'h0030 : 16'h0000, 0);
		end
		$display("t_cond done");
	endtask
	task automatic t_mskip();
		run(FC_MULTIPLE_SKIP_START, 16'h0000, 16'h005F, 1, 0, 16'h0000, 0);
		chk(16'(o_multi_skip), 16'h0000);
		run(FC_MULTIPLE_SKIP_START, 16'h0000, 16'h0060, 0, 0, 16'h0000, 0);
		chk(16'(o_multi_skip), 16'h0001);
		@(posedge i_clk) i_timer_tick <= 1'b1;
		@(posedge i_clk) i_timer_tick <= 1'b0;
		#1 chk(16'(o_timer_service), 16'h0001);
		run(10'h100, 16'h0000, 16'h0061, 1, 0, 16'h0000, 0);
		chk(16'(o_exec_enable), 16'h0000);
		run(10'h004, 16'h0400, 16'h0062, 0, 0, 16'h0000, 0);
		run(FC_MULTIPLE_SKIP_END, 16'h0000, 16'h0063, 0, 0, 16'h0000, 0);
		run(10'h100, 16'h0000, 16'h0064, 1, 0, 16'h0000, 0);
		chk(16'({o_multi_skip, o_exec_enable}), 16'h0001);
		$display("t_mskip done");
	endtask
	task automatic t_loop();
		// Only forward jumps have run so far, so the overrun flag must still be clear.
		chk(16'(o_cycle_too_long), 16'h0000);
		@(posedge i_clk) i_scan_start <= 1'b1;
		@(posedge i_clk) i_scan_start <= 1'b0;
		load(10'h007, 16'h0020);
		run(10'h004, 16'h0007, 16'h0080, 0, 0, 16'h0020, 0);
		chk(16'(o_cycle_too_long), 16'h0001);
		@(posedge i_clk) i_scan_end <= 1'b1;
		@(posedge i_clk) i_scan_end <= 1'b0;
		#1 chk(16'(o_cycle_too_long), 16'h0001);
		$display("t_loop done");
	endtask
	task automatic print_verdict();
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge i_clk);
		i_reset <= 1'b0;
		t_range();
		t_basic();
		t_cond();
		t_mskip();
		t_loop();
		print_verdict();
	end
	// The tests need under a hundred cycles; this bound leaves ample margin.
	initial begin
		repeat (3000) @(posedge i_clk);
		err_total++;
		print_verdict();
	end
endmodule
